// ### rtl/ies_pkg.sv
// Package for the interrupt entry and return sequencer.
// Assumes an 8-bit core with 16-bit addresses and a byte-wide memory port.
package ies_pkg;
  // Stack pointer after reset and the trap vector locations
  localparam logic [15:0] SP_RESET = 16'h00FF;
  localparam logic [15:0] SWI_VEC = 16'hFFFC;
  localparam logic [15:0] SRC_VEC_TOP = 16'hFFFA;
  // Register offsets on the software port
  localparam logic [2:0] REG_FLAGS = 3'h0;
  localparam logic [2:0] REG_ACK = 3'h1;
  localparam logic [2:0] REG_ENABLE = 3'h2;
  localparam logic [2:0] REG_EXT_CTL = 3'h3;
  localparam logic [2:0] REG_MASK = 3'h4;
  // Field positions
  localparam int EXT_PE_BIT = 0;
  localparam int EXT_MODE_BIT = 1;
  localparam int EXT_EDG_BIT = 2;
  localparam int EXT_FLAG_BIT = 3;
  localparam int MASK_I_BIT = 0;
  localparam int MASK_BUSY_BIT = 1;
  localparam int CCR_I_BIT = 3;
  localparam int EXT_SRC = 0;
  // Reset values
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [2:0] EXT_CTL_RESET = 3'h0;
  // Sequence lengths, as last counter values
  localparam logic [2:0] PUSH_LAST = 3'h4;
  localparam logic [2:0] VEC_READS = 3'h2;
  localparam logic [2:0] FETCH_READS = 3'h3;
  localparam logic [2:0] POP_READS = 3'h5;
  // Read tags follow each memory read to its data
  localparam logic [3:0] TAG_VEC_HI = 4'h0;
  localparam logic [3:0] TAG_VEC_LO = 4'h1;
  localparam logic [3:0] TAG_FETCH0 = 4'h2;
  localparam logic [3:0] TAG_FETCH_LAST = 4'h4;
  localparam logic [3:0] TAG_POP0 = 4'h5;
  localparam logic [3:0] TAG_POP_A = 4'h6;
  localparam logic [3:0] TAG_POP_X = 4'h7;
  localparam logic [3:0] TAG_POP_PCH = 4'h8;
  localparam logic [3:0] TAG_POP_LAST = 4'h9;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PUSH = 3'b001,
    ST_VEC = 3'b010,
    ST_FETCH = 3'b011,
    ST_POP = 3'b100
  } ies_state_e;

  typedef struct packed {
    logic [15:0] pc;
    logic [7:0] x;
    logic [7:0] a;
    logic [7:0] condition_code_reg;
  } ies_regs_s;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ies_mem_req_s;
endpackage

// ### rtl/ies_sequencer.sv
// Interrupt qualification, stacking, vector fetch and return sequencer.
// Assumes memory returns read data in the cycle after MEM_REQ.rd and
// that the core pulses INSTR_DONE, SWI_REQ and RTI_REQ at boundaries.
//
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Any source event sets read-only flag
// - Flag ignored unless local enable is 1
// - Accept maskable request only when mask 0
// - Reset sets the global mask
// - Finish current instruction before entry
// - Entry: push, mask, vector, three fetches
// - Push PC low first, condition codes last
// - Stack pointer ends at next free byte
// - Pushed PC is next instruction address
// - Return pops in reverse, restores mask
// - Return refills queue with three bytes
// - Index high byte never stacked
// - Highest fixed priority pending served first
// - Software trap uses same entry sequence
// - Clocked logic watches pin edge or level
// - Unclocked pin path wakes from stop
// - Vector high byte first, low next
// - Push order PC_LOW_BYTE, PC_HIGH_BYTE, X, A, CONDITION_CODE_REG
// - Level mode flag stuck while pin asserted
module ies_sequencer #(
  parameter int N_SRC = 8
) (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic [2:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  input wire logic [N_SRC-1:0] SRC_EVENT,
  input wire logic EXT_PIN,
  input wire logic STOP_MODE,
  output logic WAKE,
  input wire logic INSTR_DONE,
  input wire logic SWI_REQ,
  input wire logic RTI_REQ,
  input wire ies_pkg::ies_regs_s CORE_REGS,
  input wire logic SP_LD,
  input wire logic [15:0] SP_IN,
  output logic [15:0] SP_OUT,
  output logic CCR_I,
  output ies_pkg::ies_mem_req_s MEM_REQ,
  input wire logic [7:0] MEM_RDATA,
  output logic [7:0] QUEUE_BYTE,
  output logic QUEUE_VLD,
  output logic [15:0] NEW_PC,
  output ies_pkg::ies_regs_s RET_REGS,
  output logic SEQ_DONE
);
  ies_pkg::ies_state_e state_r;
  ies_pkg::ies_regs_s snap_r;
  logic [2:0] cnt_r;
  logic [15:0] vec_r;
  logic [7:0] vec_hi_r;
  logic [N_SRC-1:0] flags_r;
  logic [N_SRC-1:0] en_r;
  logic [2:0] ext_ctl_r;
  logic [2:0] sync_r;
  logic lvl_r;
  logic act_d_r;
  logic [3:0] tag_r;
  logic [3:0] tag_q_r;
  logic rd_q_r;
  logic [N_SRC-1:0] pend;
  logic [N_SRC-1:0] clr;
  logic act;
  logic ext_set;
  logic go_entry;
  logic cap;
  logic wake_req;
  logic [7:0] push_byte;

  // Lowest index wins, so source 0 (the pin) has the highest priority
  function automatic logic [15:0] pick_vec(input logic [N_SRC-1:0] p);
    logic [15:0] v;
    v = ies_pkg::SRC_VEC_TOP;
    for (int i = N_SRC - 1; i >= 0; i--)
    begin
      if (p[i])
        v = 16'(ies_pkg::SRC_VEC_TOP - 16'(2 * i));
    end
    return v;
  endfunction

  // Qualification: local enable, then global mask, at a boundary only
  assign pend = flags_r & en_r;
  assign go_entry = SWI_REQ | (INSTR_DONE & ~CCR_I & (|pend));
  assign cap = rd_q_r;
  assign act = ext_ctl_r[ies_pkg::EXT_EDG_BIT] ? lvl_r : ~lvl_r;
  assign ext_set = ext_ctl_r[ies_pkg::EXT_PE_BIT] & ((act & ~act_d_r) |
                   (ext_ctl_r[ies_pkg::EXT_MODE_BIT] & act));

  // Push data in stacking order; index high byte is not part of it
  always_comb
  begin
    unique case (cnt_r)
      3'h0: push_byte = snap_r.pc[7:0];
      3'h1: push_byte = snap_r.pc[15:8];
      3'h2: push_byte = snap_r.x;
      3'h3: push_byte = snap_r.a;
      default: push_byte = snap_r.condition_code_reg;
    endcase
  end

  // Write-one acknowledges; the pin flag also clears from its own register
  always_comb
  begin
    clr = '0;
    if (REG_WR && REG_ADDR == ies_pkg::REG_ACK)
      clr = REG_WDATA[N_SRC-1:0];
    if (REG_WR && REG_ADDR == ies_pkg::REG_EXT_CTL && REG_WDATA[ies_pkg::EXT_FLAG_BIT])
      clr[ies_pkg::EXT_SRC] = 1'b1;
  end

  // Flags: a set in the clearing cycle wins over the clear
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      flags_r <= '0;
    else
      flags_r <= SRC_EVENT | (N_SRC'(ext_set) << ies_pkg::EXT_SRC) | (flags_r & ~clr);
  end

  // Pin synchroniser; a level counts once stages two and three agree
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      sync_r <= 3'h7;
      lvl_r <= 1'b1;
      act_d_r <= 1'b0;
    end
    else
    begin
      sync_r <= {sync_r[1:0], EXT_PIN};
      if (sync_r[1] == sync_r[2])
        lvl_r <= sync_r[2];
      act_d_r <= act;
    end
  end

  // Stop wake path runs without the clock, which is halted in stop
  assign wake_req = STOP_MODE & ext_ctl_r[ies_pkg::EXT_PE_BIT] &
                    (ext_ctl_r[ies_pkg::EXT_EDG_BIT] ? EXT_PIN : ~EXT_PIN);
  always_ff @(posedge CLK or negedge RESET_N or posedge wake_req)
  begin
    if (!RESET_N)
      WAKE <= 1'b0;
    else if (wake_req)
      WAKE <= 1'b1;
    else if (!STOP_MODE)
      WAKE <= 1'b0;
  end

  // Software control registers
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      en_r <= N_SRC'(ies_pkg::ENABLE_RESET);
      ext_ctl_r <= ies_pkg::EXT_CTL_RESET;
    end
    else if (REG_WR && REG_ADDR == ies_pkg::REG_ENABLE)
      en_r <= REG_WDATA[N_SRC-1:0];
    else if (REG_WR && REG_ADDR == ies_pkg::REG_EXT_CTL)
      ext_ctl_r <= REG_WDATA[2:0];
  end

  // Read port; data stands only in the cycle after the strobe
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      REG_RDATA <= 8'h00;
    else if (!REG_RD)
      REG_RDATA <= 8'h00;
    else
    begin
      unique case (REG_ADDR)
        ies_pkg::REG_FLAGS: REG_RDATA <= 8'(flags_r);
        ies_pkg::REG_ENABLE: REG_RDATA <= 8'(en_r);
        ies_pkg::REG_EXT_CTL: REG_RDATA <= {4'h0, flags_r[ies_pkg::EXT_SRC], ext_ctl_r};
        ies_pkg::REG_MASK: REG_RDATA <= {6'h00, state_r != ies_pkg::ST_IDLE, CCR_I};
        default: REG_RDATA <= 8'h00; // Unmapped and write-only read zero
      endcase
    end
  end

  // Sequencer state; a return instruction outranks entry at a boundary
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      state_r <= ies_pkg::ST_IDLE;
      cnt_r <= 3'h0;
    end
    else
    begin
      unique case (state_r)
        ies_pkg::ST_IDLE:
        begin
          cnt_r <= 3'h0;
          if (RTI_REQ)
            state_r <= ies_pkg::ST_POP;
          else if (go_entry)
            state_r <= ies_pkg::ST_PUSH;
        end
        ies_pkg::ST_PUSH:
        begin
          cnt_r <= (cnt_r == ies_pkg::PUSH_LAST) ? 3'h0 : 3'(cnt_r + 3'h1);
          if (cnt_r == ies_pkg::PUSH_LAST)
            state_r <= ies_pkg::ST_VEC;
        end
        ies_pkg::ST_VEC:
        begin
          if (cnt_r != ies_pkg::VEC_READS)
            cnt_r <= 3'(cnt_r + 3'h1);
          if (cap && tag_q_r == ies_pkg::TAG_VEC_LO)
          begin
            state_r <= ies_pkg::ST_FETCH;
            cnt_r <= 3'h0;
          end
        end
        ies_pkg::ST_FETCH:
        begin
          if (cnt_r != ies_pkg::FETCH_READS)
            cnt_r <= 3'(cnt_r + 3'h1);
          if (cap && tag_q_r == ies_pkg::TAG_FETCH_LAST)
            state_r <= ies_pkg::ST_IDLE;
        end
        ies_pkg::ST_POP:
        begin
          if (cnt_r != ies_pkg::POP_READS)
            cnt_r <= 3'(cnt_r + 3'h1);
          if (cap && tag_q_r == ies_pkg::TAG_POP_LAST)
          begin
            state_r <= ies_pkg::ST_FETCH;
            cnt_r <= 3'h0;
          end
        end
      endcase
    end
  end

  // Snapshot at entry: next PC from the core, I bit from the mask here
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      snap_r <= '0;
      vec_r <= ies_pkg::SWI_VEC;
    end
    else if (state_r == ies_pkg::ST_IDLE && go_entry && !RTI_REQ)
    begin
      snap_r <= CORE_REGS;
      snap_r.condition_code_reg[ies_pkg::CCR_I_BIT] <= CCR_I;
      vec_r <= SWI_REQ ? ies_pkg::SWI_VEC : pick_vec(pend);
    end
  end

  // Global mask: set by reset and entry, restored by return
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      CCR_I <= 1'b1;
    else if (state_r == ies_pkg::ST_PUSH && cnt_r == ies_pkg::PUSH_LAST)
      CCR_I <= 1'b1;
    else if (cap && tag_q_r == ies_pkg::TAG_POP0)
      CCR_I <= MEM_RDATA[ies_pkg::CCR_I_BIT];
    else if (REG_WR && REG_ADDR == ies_pkg::REG_MASK)
      CCR_I <= REG_WDATA[ies_pkg::MASK_I_BIT];
  end

  // Stack pointer: write then decrement, increment then read
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      SP_OUT <= ies_pkg::SP_RESET;
    else if (state_r == ies_pkg::ST_PUSH)
      SP_OUT <= 16'(SP_OUT - 16'h0001);
    else if (state_r == ies_pkg::ST_POP && cnt_r < ies_pkg::POP_READS)
      SP_OUT <= 16'(SP_OUT + 16'h0001);
    else if (SP_LD && state_r == ies_pkg::ST_IDLE)
      SP_OUT <= SP_IN;
  end

  // Memory requests, each read tagged so its data lands in the right place
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      MEM_REQ <= '0;
      tag_r <= 4'h0;
      tag_q_r <= 4'h0;
      rd_q_r <= 1'b0;
    end
    else
    begin
      MEM_REQ.wr <= 1'b0;
      MEM_REQ.rd <= 1'b0;
      rd_q_r <= MEM_REQ.rd;
      tag_q_r <= tag_r;
      if (state_r == ies_pkg::ST_PUSH)
      begin
        MEM_REQ.wr <= 1'b1;
        MEM_REQ.addr <= SP_OUT;
        MEM_REQ.wdata <= push_byte;
      end
      else if (state_r == ies_pkg::ST_VEC && cnt_r < ies_pkg::VEC_READS)
      begin
        MEM_REQ.rd <= 1'b1;
        MEM_REQ.addr <= 16'(vec_r + 16'(cnt_r));
        tag_r <= 4'(ies_pkg::TAG_VEC_HI + 4'(cnt_r));
      end
      else if (state_r == ies_pkg::ST_FETCH && cnt_r < ies_pkg::FETCH_READS)
      begin
        MEM_REQ.rd <= 1'b1;
        MEM_REQ.addr <= 16'(NEW_PC + 16'(cnt_r));
        tag_r <= 4'(ies_pkg::TAG_FETCH0 + 4'(cnt_r));
      end
      else if (state_r == ies_pkg::ST_POP && cnt_r < ies_pkg::POP_READS)
      begin
        MEM_REQ.rd <= 1'b1;
        MEM_REQ.addr <= 16'(SP_OUT + 16'h0001);
        tag_r <= 4'(ies_pkg::TAG_POP0 + 4'(cnt_r));
      end
    end
  end

  // Read data capture: vector, popped registers and the refill queue
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      vec_hi_r <= 8'h00;
      NEW_PC <= 16'h0000;
      RET_REGS <= '0;
      QUEUE_BYTE <= 8'h00;
      QUEUE_VLD <= 1'b0;
      SEQ_DONE <= 1'b0;
    end
    else
    begin
      QUEUE_VLD <= 1'b0;
      SEQ_DONE <= 1'b0;
      if (cap)
      begin
        unique case (tag_q_r)
          ies_pkg::TAG_VEC_HI: vec_hi_r <= MEM_RDATA;
          ies_pkg::TAG_VEC_LO: NEW_PC <= {vec_hi_r, MEM_RDATA};
          ies_pkg::TAG_POP0: RET_REGS.condition_code_reg <= MEM_RDATA;
          ies_pkg::TAG_POP_A: RET_REGS.a <= MEM_RDATA;
          ies_pkg::TAG_POP_X: RET_REGS.x <= MEM_RDATA;
          ies_pkg::TAG_POP_PCH: RET_REGS.pc[15:8] <= MEM_RDATA;
          ies_pkg::TAG_POP_LAST:
          begin
            RET_REGS.pc[7:0] <= MEM_RDATA;
            NEW_PC <= {RET_REGS.pc[15:8], MEM_RDATA};
          end
          default:
          begin
            QUEUE_BYTE <= MEM_RDATA;
            QUEUE_VLD <= 1'b1;
            SEQ_DONE <= (tag_q_r == ies_pkg::TAG_FETCH_LAST);
          end
        endcase
      end
    end
  end

  // Checks; helper marks the first cycle after reset release
  logic seen_r;
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      seen_r <= 1'b0;
    else
      seen_r <= 1'b1;
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  AST_RESET_MASK: assert property (!seen_r |-> CCR_I)
    else $error("mask not set after reset");
  AST_FLAG_SET: assert property ((|SRC_EVENT) |=> (flags_r & $past(SRC_EVENT)) == $past(SRC_EVENT))
    else $error("event did not set its flag");
  AST_MASKED_IDLE: assert property (state_r == ies_pkg::ST_IDLE && CCR_I && !SWI_REQ && !RTI_REQ
    |=> state_r == ies_pkg::ST_IDLE)
    else $error("entry while masked");
  AST_BOUNDARY: assert property (state_r == ies_pkg::ST_IDLE && !INSTR_DONE && !SWI_REQ && !RTI_REQ
    |=> state_r == ies_pkg::ST_IDLE)
    else $error("entry before instruction end");
  AST_ENABLE_GATE: assert property (state_r == ies_pkg::ST_IDLE && !SWI_REQ && !RTI_REQ && (pend == '0)
    |=> state_r == ies_pkg::ST_IDLE)
    else $error("entry without enabled flag");
  AST_FIRST_PUSH: assert property (state_r == ies_pkg::ST_IDLE && go_entry && !RTI_REQ
    |-> ##2 MEM_REQ.wr && MEM_REQ.wdata == $past(CORE_REGS.pc[7:0], 2)
    && MEM_REQ.addr == $past(SP_OUT, 2))
    else $error("first push not PC low at stack pointer");
  AST_SP_AFTER: assert property (state_r == ies_pkg::ST_IDLE && go_entry && !RTI_REQ
    |-> ##6 SP_OUT == 16'($past(SP_OUT, 6) - 16'h0005) && CCR_I)
    else $error("stack pointer or mask wrong after stacking");
  AST_POP_FIRST: assert property (state_r == ies_pkg::ST_IDLE && RTI_REQ
    |-> ##2 MEM_REQ.rd && MEM_REQ.addr == 16'($past(SP_OUT, 2) + 16'h0001))
    else $error("pop does not increment before read");
  AST_LEVEL_HOLD: assert property (ext_ctl_r[ies_pkg::EXT_PE_BIT] && ext_ctl_r[ies_pkg::EXT_MODE_BIT]
    && act |=> flags_r[ies_pkg::EXT_SRC])
    else $error("level mode flag cleared while asserted");
  AST_REFILL: assert property (state_r == ies_pkg::ST_IDLE && RTI_REQ |-> ##[10:16] SEQ_DONE)
    else $error("return did not refill queue");

  COV_ENTRY: cover property (state_r == ies_pkg::ST_IDLE && go_entry && !SWI_REQ);
  COV_SWI: cover property (state_r == ies_pkg::ST_IDLE && SWI_REQ && !RTI_REQ);
  COV_RTI: cover property (SEQ_DONE && RET_REGS.condition_code_reg[ies_pkg::CCR_I_BIT] == 1'b0);
  COV_EXT: cover property (ext_set && clr[ies_pkg::EXT_SRC]);
endmodule // ies_sequencer
`default_nettype wire

// ### verification/ies_mem_model.sv
// Byte-wide memory standing on the sequencer's stack and fetch port.
// Assumes at most one request per cycle; read data follow one cycle later.
`timescale 1ns/1ps
`default_nettype none
module ies_mem_model (
  input wire logic CLK,
  input wire ies_pkg::ies_mem_req_s REQ,
  output logic [7:0] RDATA
);
  logic [7:0] mem [0:65535];
  // Known pattern, so vectors and code bytes can be predicted
  initial
  begin
    for (int i = 0; i < 65536; i++)
      mem[i] = 8'(i ^ (i >> 8));
    RDATA = 8'h00;
  end
  // Data only in the cycle after a read; it toggles otherwise, so stale use shows
  always @(posedge CLK)
  begin
    if (REQ.wr)
      mem[REQ.addr] <= REQ.wdata;
    if (REQ.rd)
      RDATA <= mem[REQ.addr];
    else
      RDATA <= ~RDATA;
  end
endmodule // ies_mem_model
`default_nettype wire

// ### verification/interrupt_entry_return_sequencer_bench.sv
// Self-checking bench for the interrupt entry and return sequencer.
// Assumes the memory model answers every read in the next cycle.
`timescale 1ns/1ps
`default_nettype none
module interrupt_entry_return_sequencer_bench;
  logic clk, reset_n, reg_wr, reg_rd, ext_pin, stop_mode, wake, ccr_i, queue_vld, seq_done;
  logic [2:0] reg_addr, ctl;
  logic [7:0] reg_wdata, reg_rdata, src_event, mem_rdata, queue_byte, rd_v;
  logic [15:0] sp_out, new_pc;
  ies_pkg::ies_regs_s core_regs, ret_regs;
  ies_pkg::ies_mem_req_s mem_req;
  logic [15:0] wa[$], ra[$];
  logic [7:0] wd[$], qb[$];
  int mismatches, tests_run, cycles;

  ies_sequencer #(.N_SRC(8)) dut (
    .CLK(clk), .RESET_N(reset_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .SRC_EVENT(src_event),
    .EXT_PIN(ext_pin), .STOP_MODE(stop_mode), .WAKE(wake), .INSTR_DONE(ctl[0]),
    .SWI_REQ(ctl[1]), .RTI_REQ(ctl[2]), .CORE_REGS(core_regs), .SP_LD(1'b0),
    .SP_IN(16'h0000), .SP_OUT(sp_out), .CCR_I(ccr_i), .MEM_REQ(mem_req),
    .MEM_RDATA(mem_rdata), .QUEUE_BYTE(queue_byte), .QUEUE_VLD(queue_vld),
    .NEW_PC(new_pc), .RET_REGS(ret_regs), .SEQ_DONE(seq_done));
  ies_mem_model u_mem (.CLK(clk), .REQ(mem_req), .RDATA(mem_rdata));

  // Clock at 250 MHz
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Log memory traffic and queue bytes as the sequencer issues them
  always @(posedge clk)
  begin
    if (mem_req.wr)
    begin
      wa.push_back(mem_req.addr);
      wd.push_back(mem_req.wdata);
    end
    if (mem_req.rd)
      ra.push_back(mem_req.addr);
    if (queue_vld)
      qb.push_back(queue_byte);
  end

  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      mismatches++;
      $display("ERROR %0t: run did not finish", $time);
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] pat(input logic [15:0] a);
    return a[7:0] ^ a[15:8];
  endfunction

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic reg_wr_t(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_rd_t(input logic [2:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    rd_v = reg_rdata;
  endtask

  // Core strobes: bit 0 boundary, bit 1 software trap, bit 2 return
  task automatic pulse(input logic [2:0] c, input logic [7:0] s);
    @(posedge clk);
    ctl <= c;
    src_event <= s;
    @(posedge clk);
    ctl <= 3'h0;
    src_event <= 8'h00;
  endtask

  task automatic clr();
    wa.delete();
    wd.delete();
    ra.delete();
    qb.delete();
  endtask

  task automatic run(input logic [2:0] c);
    int n;
    clr();
    n = 0;
    pulse(c, 8'h00);
    while (seq_done !== 1'b1 && n < 40)
    begin
      step(1);
      n++;
    end
    chk(40'(n < 40), 40'h1);
    step(1);
  endtask

  // Pushes, final stack pointer, vector and the three prefetches
  task automatic entry_chk(input logic [15:0] vec, input ies_pkg::ies_regs_s r);
    logic [15:0] tgt;
    logic [7:0] eb [5];
    tgt = {pat(vec), pat(vec + 16'h0001)};
    eb = '{r.pc[7:0], r.pc[15:8], r.x, r.a, r.condition_code_reg};
    chk(wa.size(), 5);
    for (int i = 0; i < 5; i++)
    begin
      chk(wa[i], 16'h00FF - i);
      chk(wd[i], eb[i]);
    end
    chk(sp_out, 16'h00FA);
    chk(ccr_i, 1'b1);
    chk(ra[0], vec);
    chk(ra[1], vec + 16'h0001);
    chk(new_pc, tgt);
    for (int i = 0; i < 3; i++)
    begin
      chk(ra[2 + i], tgt + i);
      chk(qb[i], pat(tgt + i));
    end
  endtask

  // Pops in reverse, restored mask and refilled queue
  task automatic ret_chk(input ies_pkg::ies_regs_s r);
    for (int i = 0; i < 5; i++)
      chk(ra[i], 16'h00FB + i);
    chk(ret_regs, r);
    chk(ccr_i, r.condition_code_reg[3]);
    chk(sp_out, 16'h00FF);
    chk(new_pc, r.pc);
    for (int i = 0; i < 3; i++)
    begin
      chk(ra[5 + i], r.pc + i);
      chk(qb[i], pat(r.pc + i));
    end
  endtask

  // Main sequence
  initial
  begin
    {reset_n, reg_wr, reg_rd, ext_pin, stop_mode} = 5'b00010;
    {reg_addr, reg_wdata, ctl, src_event} = '0;
    {mismatches, tests_run, cycles} = '0;
    core_regs = '{16'h1234, 8'h56, 8'h78, 8'hA2};
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    step(1);
    chk(ccr_i, 1'b1);
    chk(sp_out, 16'h00FF);
    reg_rd_t(ies_pkg::REG_MASK);
    chk(rd_v[1:0], 2'b01);
    reg_rd_t(ies_pkg::REG_ENABLE);
    chk(rd_v, 8'h00);
    reg_wr_t(3'h6, 8'hFF);
    reg_rd_t(3'h7);
    chk(rd_v, 8'h00);
    // Two sources pend; mask, then local enables, then boundary hold entry off
    pulse(3'h0, 8'h24);
    reg_wr_t(ies_pkg::REG_ENABLE, 8'h24);
    reg_rd_t(ies_pkg::REG_FLAGS);
    chk(rd_v, 8'h24);
    clr();
    pulse(3'h1, 8'h00);
    step(16);
    chk(wa.size(), 0);
    reg_wr_t(ies_pkg::REG_ENABLE, 8'h00);
    reg_wr_t(ies_pkg::REG_MASK, 8'h00);
    pulse(3'h1, 8'h00);
    step(16);
    chk(wa.size(), 0);
    reg_wr_t(ies_pkg::REG_ENABLE, 8'h24);
    step(16);
    chk(wa.size(), 0);
    run(3'h1);
    entry_chk(16'hFFF6, core_regs);
    reg_wr_t(ies_pkg::REG_ACK, 8'h04);
    reg_rd_t(ies_pkg::REG_FLAGS);
    chk(rd_v, 8'h20);
    // Service routine drops the mask after its ack, as nesting software would
    reg_wr_t(ies_pkg::REG_MASK, 8'h00);
    reg_rd_t(ies_pkg::REG_MASK);
    chk(rd_v[1:0], 2'b00);
    run(3'h4);
    ret_chk(core_regs);
    // Lower-priority source is served next, with other register values
    core_regs <= '{16'h2345, 8'h9A, 8'hBC, 8'h01};
    run(3'h1);
    entry_chk(16'hFFF0, core_regs);
    reg_wr_t(ies_pkg::REG_ACK, 8'h20);
    run(3'h4);
    ret_chk(core_regs);
    // Software trap enters even while masked
    reg_wr_t(ies_pkg::REG_MASK, 8'h01);
    core_regs <= '{16'h0F00, 8'h11, 8'h22, 8'hCA};
    run(3'h2);
    entry_chk(16'hFFFC, core_regs);
    run(3'h4);
    ret_chk(core_regs);
    // Pin in edge and level mode, falling polarity
    reg_wr_t(ies_pkg::REG_EXT_CTL, 8'h03);
    ext_pin <= 1'b0;
    step(8);
    reg_rd_t(ies_pkg::REG_EXT_CTL);
    chk(rd_v[3], 1'b1);
    reg_wr_t(ies_pkg::REG_EXT_CTL, 8'h0B);
    reg_rd_t(ies_pkg::REG_EXT_CTL);
    chk(rd_v[3], 1'b1);
    @(posedge clk);
    ext_pin <= 1'b1;
    step(8);
    reg_wr_t(ies_pkg::REG_EXT_CTL, 8'h0B);
    reg_rd_t(ies_pkg::REG_EXT_CTL);
    chk(rd_v[3], 1'b0);
    // Wake from stop through the pin
    @(posedge clk);
    stop_mode <= 1'b1;
    step(4);
    chk(wake, 1'b0);
    @(posedge clk);
    ext_pin <= 1'b0;
    step(2);
    chk(wake, 1'b1);
    @(posedge clk);
    stop_mode <= 1'b0;
    ext_pin <= 1'b1;
    step(2);
    chk(wake, 1'b0);
    // Edge-only mode, rising polarity: flag sets on the edge, clears while high
    reg_wr_t(ies_pkg::REG_EXT_CTL, 8'h05);
    step(4);
    reg_wr_t(ies_pkg::REG_EXT_CTL, 8'h0D);
    reg_rd_t(ies_pkg::REG_EXT_CTL);
    chk(rd_v[3], 1'b0);
    @(posedge clk);
    ext_pin <= 1'b0;
    step(8);
    @(posedge clk);
    ext_pin <= 1'b1;
    step(8);
    reg_rd_t(ies_pkg::REG_EXT_CTL);
    chk(rd_v[3], 1'b1);
    reg_wr_t(ies_pkg::REG_EXT_CTL, 8'h0D);
    reg_rd_t(ies_pkg::REG_EXT_CTL);
    chk(rd_v[3], 1'b0);
    print_verdict();
  end
endmodule // interrupt_entry_return_sequencer_bench
`default_nettype wire
